// >>> hw/rasbs_consts.svh
// constants for the reset-time agent identity and bus speed strap logic
// Overview of operation
// - Both request pins are sampled at the release of the active-low reset pin.
// - First pin active gives identity 0, second pin active gives identity 3.
// - With identity known, the request pins are mapped onto the rotated request lines.
// - Speed strap value 01 means 100 MHz and 11 means 133 MHz.
// - The processor runs only at its one specified bus frequency, 100 or 133 MHz.
// - The low speed strap bit is ignored; x0 (66 MHz) is not supported.
`ifndef RASBS_CONSTS_SVH
`define RASBS_CONSTS_SVH

`define RASBS_ID_FIRST 2'h0
`define RASBS_ID_SECOND 2'h3
`define RASBS_STRAP_100 2'h1
`define RASBS_STRAP_133 2'h3
`define RASBS_STRAP_HI_BIT 1
`define RASBS_FSB_MHZ_100 8'h64
`define RASBS_FSB_MHZ_133 8'h85

`endif

// >>> hw/rasbs_pkg.sv
// types for the reset-time agent identity and bus speed strap logic
package rasbs_pkg;

  typedef enum logic {
    RASBS_IN_RESET,
    RASBS_RUNNING
  } rasbs_phase_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic rst_prev;
    logic [1:0] req_s1;
    logic [1:0] req_s2;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    rasbs_phase_t phase;
    logic [1:0] agent_id;
    logic id_valid;
    logic id_fault;
    logic speed_133;
    logic speed_mismatch;
    logic req_first_oe;
    logic [1:0] arb_seen;
  } rasbs_state_t;

endpackage

// >>> hw/rasbs_strap.sv
// agent identity capture, request pin rotation and bus speed strap decode
`timescale 1ns/1ns
`include "rasbs_consts.svh"

module rasbs_strap
  import rasbs_pkg::*;
#(
  // set for a part built for 133 MHz, clear for a 100 MHz part
  parameter bit SPEC_FSB_133 = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic req_pin_first_n_in,
  output logic req_pin_first_n_out,
  output logic req_pin_first_n_oe,
  input wire logic req_pin_second_n,
  input wire logic [1:0] bus_speed_strap,
  input wire logic bus_req_own,
  output logic [1:0] agent_id,
  output logic id_valid,
  output logic id_fault,
  output logic bus_speed_133,
  output logic speed_mismatch,
  output logic [1:0] arbitration_request_lines
);

  rasbs_state_t st;
  rasbs_state_t next_st;
  logic release_edge;
  logic first_act;
  logic second_act;

  // pins are synchronised to the same depth so reset and pins line up
  assign release_edge = st.rst_sync[1] & ~st.rst_prev;
  assign first_act = ~st.req_s2[0];
  assign second_act = ~st.req_s2[1];

  always_comb begin
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], reset_pin_n};
    next_st.rst_prev = st.rst_sync[1];
    next_st.req_s1 = {req_pin_second_n, req_pin_first_n_in};
    next_st.req_s2 = st.req_s1;
    next_st.strap_s1 = bus_speed_strap;
    next_st.strap_s2 = st.strap_s1;

    unique case (st.phase)
      RASBS_IN_RESET: begin
        next_st.req_first_oe = 1'b0;
        if (release_edge) begin
          next_st.phase = RASBS_RUNNING;
          // exactly one pin must be active, else no identity is taken
          next_st.id_valid = first_act ^ second_act;
          next_st.id_fault = ~(first_act ^ second_act);
          if (first_act && !second_act) begin
            next_st.agent_id = `RASBS_ID_FIRST;
          end else if (second_act && !first_act) begin
            next_st.agent_id = `RASBS_ID_SECOND;
          end
          // the low strap bit plays no part in the decode
          next_st.speed_133 = st.strap_s2[`RASBS_STRAP_HI_BIT];
          next_st.speed_mismatch =
            st.strap_s2[`RASBS_STRAP_HI_BIT] != SPEC_FSB_133;
        end
      end
      RASBS_RUNNING: begin
        if (!st.rst_sync[1]) begin
          // identity is kept through reset, replaced only at release
          next_st.phase = RASBS_IN_RESET;
          next_st.req_first_oe = 1'b0;
        end else begin
          // own request always leaves on the first pin; open drain low
          next_st.req_first_oe = st.id_valid & bus_req_own;
        end
      end
    endcase

    // view of the rotated request lines from this agent's identity
    if (st.id_valid && st.agent_id == `RASBS_ID_SECOND) begin
      next_st.arb_seen = {st.req_first_oe, second_act};
    end else if (st.id_valid) begin
      next_st.arb_seen = {second_act, st.req_first_oe};
    end else begin
      next_st.arb_seen = 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.rst_sync <= 2'h0;
      st.req_s1 <= 2'h3;
      st.req_s2 <= 2'h3;
      st.phase <= RASBS_IN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // pin level is constant low; only the enable moves
  assign req_pin_first_n_out = 1'b0;
  assign req_pin_first_n_oe = st.req_first_oe;
  assign agent_id = st.agent_id;
  assign id_valid = st.id_valid;
  assign id_fault = st.id_fault;
  assign bus_speed_133 = st.speed_133;
  assign speed_mismatch = st.speed_mismatch;
  assign arbitration_request_lines = st.arb_seen;

  property p_sample_on_release;
    @(posedge mclk) disable iff (rst)
    release_edge |=> id_valid == ($past(first_act) ^ $past(second_act));
  endproperty
  a_sample_on_release: assert property (p_sample_on_release)
    else $error("identity valid does not follow pins at release");

  property p_id_first;
    @(posedge mclk) disable iff (rst)
    release_edge && first_act && !second_act |=>
      agent_id == `RASBS_ID_FIRST && id_valid && !id_fault;
  endproperty
  a_id_first: assert property (p_id_first)
    else $error("first pin active did not give identity 0");

  property p_id_second;
    @(posedge mclk) disable iff (rst)
    release_edge && second_act && !first_act |=>
      agent_id == `RASBS_ID_SECOND && id_valid && !id_fault;
  endproperty
  a_id_second: assert property (p_id_second)
    else $error("second pin active did not give identity 3");

  property p_id_hold;
    @(posedge mclk) disable iff (rst)
    !release_edge |=> $stable(agent_id) && $stable(id_valid);
  endproperty
  a_id_hold: assert property (p_id_hold)
    else $error("identity changed outside a reset release");

  property p_own_drive;
    @(posedge mclk) disable iff (rst)
    st.phase == RASBS_RUNNING && st.rst_sync[1] && id_valid && bus_req_own
      |=> req_pin_first_n_oe;
  endproperty
  a_own_drive: assert property (p_own_drive)
    else $error("own request not driven on first pin");

  property p_quiet_in_reset;
    @(posedge mclk) disable iff (rst)
    !st.rst_sync[1] |=> !req_pin_first_n_oe;
  endproperty
  a_quiet_in_reset: assert property (p_quiet_in_reset)
    else $error("first pin driven while bus is in reset");

  property p_rotation;
    @(posedge mclk) disable iff (rst)
    id_valid && agent_id == `RASBS_ID_SECOND |=>
      arbitration_request_lines[1] == $past(req_pin_first_n_oe);
  endproperty
  a_rotation: assert property (p_rotation)
    else $error("identity 3 request not on line 1");

  property p_speed_decode;
    @(posedge mclk) disable iff (rst)
    release_edge |=>
      bus_speed_133 == $past(st.strap_s2[`RASBS_STRAP_HI_BIT]) ##1
      $stable(bus_speed_133) || $past(release_edge);
  endproperty
  a_speed_decode: assert property (p_speed_decode)
    else $error("speed decode does not follow high strap bit");

  property p_mismatch;
    @(posedge mclk) disable iff (rst)
    release_edge |=> speed_mismatch ==
      ($past(st.strap_s2[`RASBS_STRAP_HI_BIT]) != SPEC_FSB_133);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("speed mismatch flag wrong");

  // a release with neither or both pins active must not yield an identity
  property p_fault_on_release;
    @(posedge mclk) disable iff (rst)
    release_edge && first_act == second_act |=> id_fault && !id_valid;
  endproperty
  a_fault_on_release: assert property (p_fault_on_release)
    else $error("ambiguous pins at release did not raise the fault");

  property p_id_range;
    @(posedge mclk) disable iff (rst)
    id_valid |->
      agent_id == `RASBS_ID_FIRST || agent_id == `RASBS_ID_SECOND;
  endproperty
  a_id_range: assert property (p_id_range)
    else $error("valid identity is neither 0 nor 3");

  // without an identity the agent must stay off the shared line
  property p_no_drive_unknown;
    @(posedge mclk) disable iff (rst)
    !id_valid |=> !req_pin_first_n_oe;
  endproperty
  a_no_drive_unknown: assert property (p_no_drive_unknown)
    else $error("first pin driven without a valid identity");

  property p_lines_idle;
    @(posedge mclk) disable iff (rst)
    !id_valid |=> arbitration_request_lines == 2'h0;
  endproperty
  a_lines_idle: assert property (p_lines_idle)
    else $error("request lines shown without a valid identity");

  property p_rotation_first;
    @(posedge mclk) disable iff (rst)
    id_valid && agent_id == `RASBS_ID_FIRST |=>
      arbitration_request_lines[0] == $past(req_pin_first_n_oe);
  endproperty
  a_rotation_first: assert property (p_rotation_first)
    else $error("identity 0 request not on line 0");

  // a part runs at one bus rate, so the decode may move only at a release
  property p_speed_hold;
    @(posedge mclk) disable iff (rst)
    !release_edge |=> $stable(bus_speed_133) && $stable(speed_mismatch);
  endproperty
  a_speed_hold: assert property (p_speed_hold)
    else $error("speed decode changed outside a reset release");

endmodule // rasbs_strap

// >>> sim/rasbs_far_side.sv
// board side model: central agent, rotated request line, speed strap
`timescale 1ns/1ns
module rasbs_far_side (
  input wire logic mclk,
  input wire logic reset_pin_n,
  input wire logic as_agent1,
  input wire logic no_agent,
  input wire logic other_req,
  input wire logic board_133,
  input wire logic strap_low,
  output logic cfg_first_n,
  output logic cfg_second_n,
  output logic [1:0] bus_speed_strap
);
  logic [2:0] hold;
  always_ff @(posedge mclk) begin
    if (!reset_pin_n) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  // line 0 held through reset and a short hold; released lines pull high
  wire cfg = !reset_pin_n || hold != 3'h0;
  // no_agent alone leaves both lines idle; with as_agent1 both are pulled
  assign cfg_first_n = !(cfg && !(no_agent ^ as_agent1));
  assign cfg_second_n = cfg ? !as_agent1 : !other_req;
  assign bus_speed_strap = {board_133, strap_low};
endmodule // rasbs_far_side

// >>> sim/rasbs_strap_tb_top.sv
// testbench for the agent identity and bus speed strap logic
`timescale 1ns/1ns
module rasbs_strap_tb_top;
  logic mclk = 0, rst = 1, reset_pin_n = 0, bus_req_own = 0;
  logic as_agent1 = 0, no_agent = 0, other_req = 0, board_133 = 0;
  logic strap_low = 0, prv = 0, prv2 = 0;
  logic first_out, first_oe, cfg_first_n, second_n;
  logic id_valid, id_fault, bus_speed_133, speed_mismatch;
  logic [1:0] strap, agent_id, arb, last_id;
  int seed = 38487, fail_count = 0, total_checks = 0, i, k;
  // open-drain first pin: low when either party pulls it
  wire first_wire = cfg_first_n & ~(first_oe & ~first_out);
  // one bus clock shared by both sides
  initial begin
    forever #5 mclk = ~mclk;
  end
  rasbs_strap dut (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n),
    .req_pin_first_n_in(first_wire), .req_pin_first_n_out(first_out),
    .req_pin_first_n_oe(first_oe), .req_pin_second_n(second_n),
    .bus_speed_strap(strap), .bus_req_own(bus_req_own),
    .agent_id(agent_id), .id_valid(id_valid), .id_fault(id_fault),
    .bus_speed_133(bus_speed_133), .speed_mismatch(speed_mismatch),
    .arbitration_request_lines(arb));
  rasbs_far_side far (.mclk(mclk), .reset_pin_n(reset_pin_n),
    .as_agent1(as_agent1), .no_agent(no_agent), .other_req(other_req),
    .board_133(board_133), .strap_low(strap_low),
    .cfg_first_n(cfg_first_n), .cfg_second_n(second_n),
    .bus_speed_strap(strap));
  task automatic check(input string what, input logic [1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [1:0] exp_id(input logic a1);
    return a1 ? 2'h3 : 2'h0;
  endfunction
  // id 0 sees line 1 on its second pin, id 3 the other way round
  function automatic logic [1:0] exp_lines(input logic a1, nf, own, oth);
    if (nf) return 2'h0;
    return a1 ? {own, oth} : {oth, own};
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input logic a1, input logic nf, input logic b);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    as_agent1 <= a1;
    no_agent <= nf;
    board_133 <= b;
    strap_low <= 1'($random(seed));
    other_req <= 1'($random(seed));
    repeat (6) @(posedge mclk);
    check("oe in reset", first_oe, 2'h0);
    check("pin level", first_out, 2'h0);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    check("id_valid", id_valid, !nf);
    check("id_fault", id_fault, nf);
    check("agent_id", agent_id, nf ? last_id : exp_id(a1));
    check("bus_speed_133", bus_speed_133, b);
    check("speed_mismatch", speed_mismatch, !b);
    if (!nf) last_id = exp_id(a1);
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      prv2 = prv;
      prv = bus_req_own;
      bus_req_own <= 1'($random(seed));
      #1;
      check("oe", first_oe, prv & !nf);
      if (k > 0)
        check("arb", arb, exp_lines(a1, nf, prv2, other_req));
      check("agent_id hold", agent_id, last_id);
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    run(0, 0, 1);
    run(1, 0, 0);
    run(1, 1, 1);
    run(0, 0, 0);
    run(0, 1, 0);
    for (i = 0; i < 6; i++)
      run(1'($random(seed)), ($random(seed) & 3) == 0, 1'($random(seed)));
    give_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end
endmodule // rasbs_strap_tb_top
